// ==== common/atw_pkg.sv ====
// constants and types for the two-wire readout controller
// assumes one system clock of 40 MHz and a separate modulator clock
// Summary of operation
// - output idles high with nothing pending
// - new result drives output low until clocking
// - each serial rising edge presents next bit
// - sixteen bits, msb first, two's complement
// - 25th pulse returns output to idle high
// - without 25th pulse output keeps last bit
// - unread result overwritten by newer result
// - 26th pulse falling edge starts calibration
// - after calibration new data gives falling edge
// - output high once sleep is entered
// - clock low wakes, conversion restarts
// - long 26th high calibrates at wake-up
// - read-only link, control by clock timing
// - reset runs a self-calibration first
// - oscillator off while external clock present
package atw_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int         RES_BITS       = 16;
    localparam int         FIFO_DEPTH     = 8;
    localparam logic [4:0] CNT_LAST_DATA  = 5'h10;
    localparam logic [4:0] CNT_PRE_IDLE   = 5'h18;
    localparam logic [4:0] CNT_CAL_PULSE  = 5'h1A;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SLEEP_HOLD_NS = 10000;
    localparam int SLEEP_CYC     = (SLEEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_TIME_NS   = 50000;
    localparam int CAL_CYC       = CAL_TIME_NS / CLK_PERIOD_NS;
    localparam int OSC_A_HZ      = 2457600;
    localparam int OSC_B_HZ      = 2252800;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [RES_BITS-1:0] code;
    } atw_result_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_SHIFT,
        ST_POST,
        ST_SLEEP,
        ST_CAL
    } atw_state_e;

endpackage

// ==== src/atw_readout.sv ====
// result fifo and two-wire readout controller
// assumes sclk and ext_clk_det are raw pins; conv_valid, conv_data, conv_ready live on mod_clk, conv_run on clk

// ------------------------------------------------------------
// result fifo
// ------------------------------------------------------------
module atw_fifo
    import atw_pkg::*;
#(
    parameter int W = RES_BITS,
    parameter int D = FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         clear,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready && !clear;
    assign pop       = out_valid && out_ready && !clear;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || clear) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // atw_fifo

// ------------------------------------------------------------
// readout controller
// ------------------------------------------------------------
module atw_readout
    import atw_pkg::*;
#(
    parameter int SLEEP_HOLD = SLEEP_CYC,
    parameter int CAL_LEN    = CAL_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        sclk,
    input  wire logic        ext_clk_det,
    input  wire logic        mod_clk,
    input  wire logic        mod_reset_n,
    input  wire logic        conv_valid,
    input  wire atw_result_s conv_data,
    output logic             conv_ready,
    output logic             dout_rdy_n,
    output logic             conv_run,
    output logic             cal_busy,
    output logic             sleeping,
    output logic             osc_en
);
    // ------------------------------------------------------------
    // modulator-side capture, toggle handshake
    // ------------------------------------------------------------
    atw_result_s cap_q;
    logic        req_t_q;
    logic        ack_m1_q;
    logic        ack_m2_q;
    logic        ack_t_q;

    // ready stays low until the word has crossed, so a full fifo stalls the source
    always_ff @(posedge mod_clk) begin
        if (!mod_reset_n) begin
            cap_q      <= '0;
            req_t_q    <= 1'b0;
            conv_ready <= 1'b1;
        end else if (conv_ready && conv_valid) begin
            cap_q      <= conv_data;
            req_t_q    <= ~req_t_q;
            conv_ready <= 1'b0;
        end else if (!conv_ready && ack_m2_q == req_t_q) begin
            conv_ready <= 1'b1;
        end
    end

    always_ff @(posedge mod_clk) begin
        if (!mod_reset_n) begin
            ack_m1_q <= 1'b0;
            ack_m2_q <= 1'b0;
        end else begin
            ack_m1_q <= ack_t_q;
            ack_m2_q <= ack_m1_q;
        end
    end

    // ------------------------------------------------------------
    // system-side synchronisers
    // ------------------------------------------------------------
    logic req_s1_q, req_s2_q;
    logic sc1_q, sc2_q, sc3_q;
    logic ex1_q, ex2_q;
    logic rise, fall;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            sc1_q    <= 1'b0;
            sc2_q    <= 1'b0;
            sc3_q    <= 1'b0;
            ex1_q    <= 1'b0;
            ex2_q    <= 1'b0;
        end else begin
            req_s1_q <= req_t_q;
            req_s2_q <= req_s1_q;
            sc1_q    <= sclk;
            sc2_q    <= sc1_q;
            sc3_q    <= sc2_q;
            ex1_q    <= ext_clk_det;
            ex2_q    <= ex1_q;
        end
    end

    assign rise = sc2_q && !sc3_q;
    assign fall = !sc2_q && sc3_q;

    // internal oscillator shut down while an external clock is detected
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            osc_en <= 1'b1;
        end else begin
            osc_en <= !ex2_q;
        end
    end

    // ------------------------------------------------------------
    // fifo fill and drain
    // ------------------------------------------------------------
    atw_state_e  state_q;
    atw_result_s fifo_out;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        drain_ok;
    logic        pop;
    logic        push_req;
    logic        fifo_clear;

    assign push_req   = req_s2_q != ack_t_q;
    assign drain_ok   = state_q != ST_SLEEP && state_q != ST_CAL;
    assign pop        = fifo_out_valid && drain_ok;
    // results made before sleep or calibration are stale and dropped
    assign fifo_clear = !drain_ok;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_t_q <= 1'b0;
        end else if (push_req && fifo_in_ready) begin
            ack_t_q <= req_s2_q;
        end
    end

    atw_fifo #(
        .W (RES_BITS),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .clear     (fifo_clear),
        .in_valid  (push_req),
        .in_data   (cap_q),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out),
        .out_ready (drain_ok)
    );

    // ------------------------------------------------------------
    // high-phase timer
    // ------------------------------------------------------------
    logic [15:0] hi_cnt_q;
    logic        long_hi;

    always_ff @(posedge clk) begin
        if (!reset_n || !sc2_q) begin
            hi_cnt_q <= '0;
        end else if (!long_hi) begin
            hi_cnt_q <= hi_cnt_q + 16'h0001;
        end
    end

    assign long_hi = hi_cnt_q >= 16'(SLEEP_HOLD);

    // ------------------------------------------------------------
    // readout state machine
    // ------------------------------------------------------------
    atw_result_s hold_q;
    logic [4:0]  cnt_q;
    logic [15:0] cal_q;
    logic        wake_cal_q;

    function automatic logic bit_at(atw_result_s r, logic [4:0] idx);
        bit_at = r.code[4'(RES_BITS - 1) - idx[3:0]];
    endfunction

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q    <= ST_CAL;
            hold_q     <= '0;
            cnt_q      <= '0;
            cal_q      <= '0;
            wake_cal_q <= 1'b0;
            dout_rdy_n <= 1'b1;
        end else begin
            unique case (state_q)
                ST_CAL: begin
                    dout_rdy_n <= 1'b1;
                    cal_q      <= cal_q + 16'h0001;
                    if (cal_q == 16'(CAL_LEN - 1)) begin
                        cal_q   <= '0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    dout_rdy_n <= 1'b1;
                    if (pop) begin
                        hold_q     <= fifo_out;
                        cnt_q      <= '0;
                        dout_rdy_n <= 1'b0;
                        state_q    <= ST_READY;
                    end
                end
                ST_READY, ST_SHIFT: begin
                    if (pop) begin
                        hold_q     <= fifo_out;
                        cnt_q      <= '0;
                        dout_rdy_n <= 1'b0;
                        state_q    <= ST_READY;
                    end else if (long_hi) begin
                        wake_cal_q <= 1'b0;
                        dout_rdy_n <= 1'b1;
                        state_q    <= ST_SLEEP;
                    end else if (rise) begin
                        cnt_q   <= cnt_q + 5'h01;
                        state_q <= ST_SHIFT;
                        if (cnt_q < CNT_LAST_DATA) begin
                            dout_rdy_n <= bit_at(hold_q, cnt_q);
                        end
                        if (cnt_q == CNT_PRE_IDLE) begin
                            dout_rdy_n <= 1'b1;
                            state_q    <= ST_POST;
                        end
                    end
                    // no edge: the last shifted bit simply stays
                end
                ST_POST: begin
                    if (pop) begin
                        hold_q     <= fifo_out;
                        cnt_q      <= '0;
                        dout_rdy_n <= 1'b0;
                        state_q    <= ST_READY;
                    end else if (rise && cnt_q != CNT_CAL_PULSE) begin
                        cnt_q <= cnt_q + 5'h01;
                    end else if (long_hi && cnt_q == CNT_CAL_PULSE) begin
                        wake_cal_q <= 1'b1;
                        state_q    <= ST_SLEEP;
                    end else if (fall && cnt_q == CNT_CAL_PULSE) begin
                        state_q <= ST_CAL;
                    end
                end
                ST_SLEEP: begin
                    dout_rdy_n <= 1'b1;
                    cnt_q      <= '0;
                    if (!sc2_q) begin
                        state_q <= wake_cal_q ? ST_CAL : ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            conv_run <= 1'b0;
            cal_busy <= 1'b1;
            sleeping <= 1'b0;
        end else begin
            conv_run <= drain_ok;
            cal_busy <= state_q == ST_CAL;
            sleeping <= state_q == ST_SLEEP;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic act;
    assign act = state_q == ST_READY || state_q == ST_SHIFT;

    AST_IDLE_HIGH: assert property (
        state_q == ST_IDLE && !$past(pop) |-> dout_rdy_n)
        else $error("output not high while idle");
    AST_READY_LOW: assert property (
        state_q == ST_READY |-> !dout_rdy_n)
        else $error("output not low while result pending");
    AST_MSB_FIRST: assert property (
        state_q == ST_READY && rise && !pop && !long_hi
        |=> dout_rdy_n == $past(hold_q.code[RES_BITS-1]) && cnt_q == 5'h01)
        else $error("first bit is not the msb");
    AST_IDLE_25TH: assert property (
        act && rise && cnt_q == CNT_PRE_IDLE && !pop && !long_hi
        |=> dout_rdy_n && state_q == ST_POST)
        else $error("25th pulse did not return output high");
    AST_HOLD_LAST: assert property (
        state_q == ST_SHIFT && !rise && !pop && !long_hi |=> $stable(dout_rdy_n))
        else $error("output moved without a serial edge");
    AST_OVERWRITE: assert property (
        act && pop |=> hold_q == $past(fifo_out) && state_q == ST_READY && cnt_q == 5'h00)
        else $error("new result did not replace unread one");
    AST_CAL_26TH: assert property (
        state_q == ST_POST && cnt_q == CNT_CAL_PULSE && fall && !pop && !long_hi
        |=> state_q == ST_CAL ##1 cal_busy)
        else $error("26th falling edge did not start calibration");
    AST_CAL_DONE: assert property (
        state_q == ST_CAL && cal_q == 16'(CAL_LEN - 1) |=> state_q == ST_IDLE && dout_rdy_n)
        else $error("calibration did not end on time");
    AST_SLEEP_HIGH: assert property (
        state_q == ST_SLEEP |-> dout_rdy_n ##1 sleeping || !sc2_q)
        else $error("output not high in sleep");
    AST_WAKE: assert property (
        state_q == ST_SLEEP && !sc2_q
        |=> state_q == ($past(wake_cal_q) ? ST_CAL : ST_IDLE))
        else $error("wrong wake-up path");
    AST_SHORT_HIGH: assert property (
        act && !long_hi && !pop |=> state_q != ST_SLEEP)
        else $error("sleep entered on a short high phase");
    AST_OSC_OFF: assert property (
        ex2_q [*3] |=> !osc_en)
        else $error("oscillator left on with external clock");

    COV_READ_25: cover property (state_q == ST_SHIFT ##1 state_q == ST_POST);
    COV_CAL_26:  cover property (state_q == ST_POST ##1 state_q == ST_CAL);
    COV_SLEEP:   cover property (act ##1 state_q == ST_SLEEP);
    COV_WAKECAL: cover property (state_q == ST_SLEEP && wake_cal_q ##1 state_q == ST_CAL);
endmodule // atw_readout

// ==== verification/atw_host.sv ====
// host model: drives the serial clock, samples the ready/data line
// assumes the device synchronises sclk, so high phases of 5 clk and low phases of 6 clk or more are safe
module atw_host
    import atw_pkg::*;
(
    input  wire logic clk,
    input  wire logic dout_rdy_n,
    output logic      sclk
);
    timeunit 1ns;
    timeprecision 1ps;

    initial sclk = 1'b0;

    task automatic set_sclk(input logic v);
        @(posedge clk);
        sclk <= v;
    endtask

    // short high phase stays well below the sleep hold
    task automatic pulse(input int hi);
        set_sclk(1'b1);
        repeat (hi - 1) @(posedge clk);
        sclk <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic wait_low(output logic ok);
        int n;
        n = 0;
        while (dout_rdy_n !== 1'b0 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = (dout_rdy_n === 1'b0);
    endtask

    // n pulses; line level after each is shifted in
    task automatic read(input int n, output logic [23:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            pulse(6);
            v = {v[22:0], dout_rdy_n};
        end
    endtask
endmodule // atw_host

// ==== verification/tb_atw_readout.sv ====
// testbench for the two-wire readout controller
// assumes a 40 MHz system clock and an unrelated 160 ns modulator clock
module tb_atw_readout
    import atw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SLEEP_T = 16;
    localparam int CAL_T   = 20;

    logic        clk;
    logic        reset_n;
    logic        sclk;
    logic        ext_clk_det;
    logic        mod_clk;
    logic        mod_reset_n;
    logic        conv_valid;
    atw_result_s conv_data;
    logic        conv_ready;
    logic        dout_rdy_n;
    logic        conv_run;
    logic        cal_busy;
    logic        sleeping;
    logic        osc_en;
    int          error_cnt = 0;
    int          total_checks = 0;

    // both resets start asserted, stimulus lines start idle
    initial begin
        clk         = 1'b0;
        mod_clk     = 1'b0;
        reset_n     = 1'b0;
        mod_reset_n = 1'b0;
        ext_clk_det = 1'b0;
        conv_valid  = 1'b0;
        conv_data   = '0;
    end

    always #12.5 clk = ~clk;
    always #80 mod_clk = ~mod_clk;

    atw_readout #(.SLEEP_HOLD(SLEEP_T), .CAL_LEN(CAL_T)) u_dut (
        .clk(clk), .reset_n(reset_n), .sclk(sclk), .ext_clk_det(ext_clk_det),
        .mod_clk(mod_clk), .mod_reset_n(mod_reset_n), .conv_valid(conv_valid),
        .conv_data(conv_data), .conv_ready(conv_ready), .dout_rdy_n(dout_rdy_n),
        .conv_run(conv_run), .cal_busy(cal_busy), .sleeping(sleeping), .osc_en(osc_en)
    );

    atw_host u_host (.clk(clk), .dout_rdy_n(dout_rdy_n), .sclk(sclk));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // word held until sampled with ready; data inverted once released
    task automatic push(input logic [15:0] d);
        logic ok;
        @(posedge mod_clk);
        conv_valid <= 1'b1;
        conv_data  <= atw_result_s'(d);
        for (int n = 0; n < 60; n++) begin
            #1 ok = (conv_ready === 1'b1);
            @(posedge mod_clk);
            if (ok) break;
        end
        conv_valid <= 1'b0;
        conv_data  <= atw_result_s'(~d);
        chk(24'(ok), 24'h1);
    endtask

    task automatic wait_cal();
        for (int n = 0; n < 200 && cal_busy !== 1'b0; n++) @(posedge clk);
        #1 chk(24'(cal_busy), 24'h0);
    endtask

    task automatic read_all(input logic [15:0] d);
        logic        ok;
        logic [23:0] v;
        u_host.wait_low(ok);
        chk(24'(ok), 24'h1);
        u_host.read(24, v);
        chk(v, {d, {8{d[0]}}});
        u_host.pulse(6);
        chk(24'(dout_rdy_n), 24'h1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 chk({22'h0, cal_busy, dout_rdy_n}, 24'h3);
        repeat (3) @(posedge mod_clk);
        mod_reset_n <= 1'b1;
        wait_cal();
        repeat (4) @(posedge clk);
        #1 chk({22'h0, conv_run, dout_rdy_n}, 24'h3);
    endtask

    task automatic t_read();
        push(16'h8F35);
        repeat (40) @(posedge clk);
        #1 chk(24'(dout_rdy_n), 24'h0);
        read_all(16'h8F35);
        repeat (40) @(posedge clk);
        #1 chk(24'(dout_rdy_n), 24'h1);
    endtask

    task automatic t_over();
        push(16'h1234);
        push(16'h00A4);
        repeat (40) @(posedge clk);
        read_all(16'h00A4);
    endtask

    task automatic t_cal();
        push(16'h7FFE);
        read_all(16'h7FFE);
        u_host.pulse(6);
        #1 chk({22'h0, cal_busy, dout_rdy_n}, 24'h3);
        wait_cal();
        push(16'h0001);
        read_all(16'h0001);
    endtask

    task automatic t_sleep();
        logic        ok;
        logic [23:0] v;
        push(16'hC003);
        u_host.wait_low(ok);
        chk(24'(ok), 24'h1);
        u_host.read(4, v);
        chk(v, 24'hC);
        u_host.set_sclk(1'b1);
        repeat (SLEEP_T + 12) @(posedge clk);
        #1 chk({22'h0, sleeping, dout_rdy_n}, 24'h3);
        u_host.set_sclk(1'b0);
        repeat (10) @(posedge clk);
        #1 chk({22'h0, sleeping, conv_run}, 24'h1);
        push(16'h4242);
        read_all(16'h4242);
    endtask

    task automatic t_wakecal();
        logic        ok;
        logic [23:0] v;
        push(16'h5A5B);
        u_host.wait_low(ok);
        chk(24'(ok), 24'h1);
        u_host.read(24, v);
        u_host.pulse(6);
        u_host.set_sclk(1'b1);
        repeat (SLEEP_T + 12) @(posedge clk);
        #1 chk(24'(sleeping), 24'h1);
        u_host.set_sclk(1'b0);
        repeat (8) @(posedge clk);
        #1 chk(24'(cal_busy), 24'h1);
        wait_cal();
        push(16'hFFFF);
        read_all(16'hFFFF);
    endtask

    task automatic t_osc();
        @(posedge clk);
        ext_clk_det <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk(24'(osc_en), 24'h0);
        @(posedge clk);
        ext_clk_det <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(24'(osc_en), 24'h1);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    initial begin
        t_reset();
        t_read();
        t_over();
        t_cal();
        t_sleep();
        t_wakecal();
        t_osc();
        conclude();
    end
endmodule // tb_atw_readout
